// ==== torque_off_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing figures of the
 * torque-off monitor.
 * Assumes a 125 MHz control clock and a 32-bit APB register bus.
 */
`ifndef TORQUE_OFF_REGS_SVH
`define TORQUE_OFF_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_CONTROL 12'h000
`define OFS_INPUT_STATUS 12'h004
`define OFS_ERROR 12'h008
`define OFS_DRIVE_STATE 12'h00C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTL_ENABLE_BIT 0
`define CTL_DISABLE_BIT 1
`define CTL_CLEAR_BIT 2
`define STS_TORQUE_OFF_BIT 24
`define ERR_ENOFF_BIT 0
`define ERR_FAULT_BIT 1
`define ERR_UNDEF_BIT 14
`define DST_ENABLED_BIT 0
`define DST_GATE_BIT 1

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define CLK_MHZ 125
`define TEST_PULSE_US 1000
`define MS_US 1000
`define UNDEF_LIMIT_MS 500
`define RESP_MAX_MS 120

`endif

// ==== torque_off_pkg.sv ====
/*
 * Types of the torque-off monitor: drive state and the packed state record.
 * Assumes the register header is on the include path.
 */
`default_nettype none
`include "torque_off_regs.svh"

package torque_off_pkg;

    // ------------------------------------------------------------------------
    // drive enable state
    // ------------------------------------------------------------------------
    typedef enum logic [0:0]
    {
        DRV_DISABLED = 1'b0,
        DRV_ENABLED = 1'b1
    } drive_state_t;

    // ------------------------------------------------------------------------
    // complete register state of the monitor
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        logic [2:0] req_s;
        logic [2:0] und_s;
        logic [2:0] flt_s;
        logic [2:0] boot_s;
        logic req_hi;
        logic und_hi;
        logic flt_hi;
        logic boot_hi;
        logic req_ok;
        logic [31:0] low_cnt;
        logic [31:0] tick_cnt;
        logic [31:0] und_ms;
        logic err_undef;
        logic alm_enoff;
        logic alm_fault;
        drive_state_t drv;
        logic drv_en;
        logic lamp;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mon_state_t;

endpackage : torque_off_pkg

`default_nettype wire

// ==== torque_off_monitor.sv ====
/*
 * Torque-off monitor: filters the active-low torque-off request, switches the
 * gate-driver supply, sequences drive enabling, raises alarms and reports
 * status over APB.
 * Assumes pins arrive asynchronously, an external comparator flags the
 * undefined input band, and an APB master on the same 125 MHz clock.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "torque_off_regs.svh"

// Function
// - request high permits drive enabling
// - request low removes gate supply, blocks start
// - re-enable needs high, cleared alarms, command
// - torque removal never bypassed by configuration
// - low pulses under 1 ms ignored
// - torque-off state shown in status bit 24
// - lamp on only with voltage, no fault
// - lamp meaning valid only after start-up
// - undefined band over 500 ms sets error bit 14
// - gate supply off within 120 ms
// - fault alarms never interfere with removal
// - request input is active low
// - enable while low latches alarm until cleared
module torque_off_monitor #(
    parameter int unsigned LOW_QUAL_CYC = `TEST_PULSE_US * `CLK_MHZ,
    parameter int unsigned MS_CYC = `MS_US * `CLK_MHZ
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic TORQUE_OFF_REQUEST_N,
    input wire logic UNDEFINED_BAND,
    input wire logic CIRCUIT_FAULT,
    input wire logic STARTUP_DONE,
    output logic GATE_SUPPLY_EN,
    output logic DRIVE_ENABLE,
    output logic SAFETY_STATE_LAMP,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // filtered level moves only once the second and third stages agree
    function automatic logic settle(input logic [2:0] s, input logic old);
        settle = (s[1] == s[2]) ? s[1] : old;
    endfunction : settle

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    torque_off_pkg::mon_state_t st_r;
    torque_off_pkg::mon_state_t st_nxt;
    logic setup_ph;
    logic wr_take;
    logic cmd_enable;
    logic cmd_disable;
    logic cmd_clear;
    logic alarms_pending;
    logic ms_tick;

    // bus phase decode and command strobes
    assign setup_ph = PSEL && !PENABLE;
    assign wr_take = PSEL && PENABLE && st_r.pready && PWRITE;
    assign cmd_enable = wr_take && (PADDR == `OFS_CONTROL) && PWDATA[`CTL_ENABLE_BIT];
    assign cmd_disable = wr_take && (PADDR == `OFS_CONTROL) && PWDATA[`CTL_DISABLE_BIT];
    assign cmd_clear = wr_take && (PADDR == `OFS_CONTROL) && PWDATA[`CTL_CLEAR_BIT];
    assign alarms_pending = st_r.err_undef || st_r.alm_enoff || st_r.alm_fault;
    assign ms_tick = (st_r.tick_cnt == 32'(MS_CYC - 1));

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // three-stage synchronisers for all four input pins other than APB, clock and reset
        st_nxt.req_s = {st_r.req_s[1:0], TORQUE_OFF_REQUEST_N};
        st_nxt.und_s = {st_r.und_s[1:0], UNDEFINED_BAND};
        st_nxt.flt_s = {st_r.flt_s[1:0], CIRCUIT_FAULT};
        st_nxt.boot_s = {st_r.boot_s[1:0], STARTUP_DONE};
        st_nxt.req_hi = settle(st_r.req_s, st_r.req_hi);
        st_nxt.und_hi = settle(st_r.und_s, st_r.und_hi);
        st_nxt.flt_hi = settle(st_r.flt_s, st_r.flt_hi);
        st_nxt.boot_hi = settle(st_r.boot_s, st_r.boot_hi);

        // low request removes gate supply only after the test-pulse window;
        // no register bit reaches this path
        if (st_r.req_hi)
        begin
            st_nxt.low_cnt = 32'h0000_0000;
            st_nxt.req_ok = 1'b1;
        end
        else if (st_r.low_cnt == 32'(LOW_QUAL_CYC - 1))
        begin
            st_nxt.req_ok = 1'b0;
        end
        else
        begin
            st_nxt.low_cnt = st_r.low_cnt + 32'h0000_0001;
        end

        // millisecond prescaler and undefined-band timer
        st_nxt.tick_cnt = ms_tick ? 32'h0000_0000 : st_r.tick_cnt + 32'h0000_0001;
        if (!st_r.und_hi)
        begin
            st_nxt.und_ms = 32'h0000_0000;
        end
        else if (ms_tick && st_r.und_ms != 32'hFFFF_FFFF)
        begin
            st_nxt.und_ms = st_r.und_ms + 32'h0000_0001;
        end

        // alarm clear first, so that a same-cycle event overrides it
        if (cmd_clear)
        begin
            st_nxt.err_undef = 1'b0;
            st_nxt.alm_enoff = 1'b0;
            st_nxt.alm_fault = 1'b0;
        end
        if (st_r.und_hi && ms_tick && st_r.und_ms == 32'(`UNDEF_LIMIT_MS))
        begin
            st_nxt.err_undef = 1'b1;
        end
        if (st_r.flt_hi)
        begin
            st_nxt.alm_fault = 1'b1;
        end
        if (cmd_enable && !st_r.req_hi)
        begin
            st_nxt.alm_enoff = 1'b1;
        end

        // drive enable sequencing
        case (st_r.drv)
            torque_off_pkg::DRV_DISABLED:
            begin
                if (cmd_enable && st_r.req_hi && st_r.req_ok && !alarms_pending)
                begin
                    st_nxt.drv = torque_off_pkg::DRV_ENABLED;
                end
            end
            torque_off_pkg::DRV_ENABLED:
            begin
                // a qualified removal or a disable command drops the drive; test pulses do not
                if (cmd_disable || !st_r.req_ok)
                begin
                    st_nxt.drv = torque_off_pkg::DRV_DISABLED;
                end
            end
            default:
            begin
                st_nxt.drv = torque_off_pkg::DRV_DISABLED;
            end
        endcase
        st_nxt.drv_en = (st_nxt.drv == torque_off_pkg::DRV_ENABLED) && st_nxt.req_ok;

        // lamp: dark during start-up, then voltage present, no fault and no alarm pending
        st_nxt.lamp = st_r.boot_hi && st_r.req_hi && !st_r.flt_hi
            && !alarms_pending;

        // APB slave, no wait state: answer in the first access cycle
        st_nxt.pready = setup_ph;
        st_nxt.pslverr = 1'b0;
        if (setup_ph)
        begin
            st_nxt.prdata = `RST_WORD;
            if (PADDR == `OFS_CONTROL)
            begin
                st_nxt.prdata = `RST_WORD;
            end
            else if (PADDR == `OFS_INPUT_STATUS)
            begin
                st_nxt.prdata[`STS_TORQUE_OFF_BIT] = st_r.req_hi;
            end
            else if (PADDR == `OFS_ERROR)
            begin
                st_nxt.prdata[`ERR_ENOFF_BIT] = st_r.alm_enoff;
                st_nxt.prdata[`ERR_FAULT_BIT] = st_r.alm_fault;
                st_nxt.prdata[`ERR_UNDEF_BIT] = st_r.err_undef;
            end
            else if (PADDR == `OFS_DRIVE_STATE)
            begin
                st_nxt.prdata[`DST_ENABLED_BIT] = st_r.drv_en;
                st_nxt.prdata[`DST_GATE_BIT] = st_r.req_ok;
            end
            else
            begin
                st_nxt.pslverr = 1'b1; // unmapped address
            end
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign GATE_SUPPLY_EN = st_r.req_ok;
    assign DRIVE_ENABLE = st_r.drv_en;
    assign SAFETY_STATE_LAMP = st_r.lamp;
    assign PRDATA = st_r.prdata;
    assign PREADY = st_r.pready;
    assign PSLVERR = st_r.pslverr;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence enable_ok_s;
        cmd_enable && st_r.req_hi && st_r.req_ok && !alarms_pending;
    endsequence

    sequence status_read_s;
        setup_ph && PADDR == `OFS_INPUT_STATUS;
    endsequence

    removal_delay_a: assert property (
        !st_r.req_hi && st_r.req_ok && st_r.low_cnt == 32'(LOW_QUAL_CYC - 1)
        |=> !GATE_SUPPLY_EN && !DRIVE_ENABLE)
        else $error("gate supply not removed after qualified low");

    pulse_ignore_a: assert property (
        st_r.req_ok && !st_r.req_hi && st_r.low_cnt < 32'(LOW_QUAL_CYC - 1)
        |=> GATE_SUPPLY_EN)
        else $error("short low pulse removed torque");

    release_a: assert property (
        !st_r.req_ok && st_r.req_hi |=> GATE_SUPPLY_EN)
        else $error("high request did not restore gate supply");

    torque_block_a: assert property (
        !GATE_SUPPLY_EN |-> !DRIVE_ENABLE)
        else $error("drive enabled without gate supply");

    enable_seq_a: assert property (
        enable_ok_s ##1 st_r.req_ok |-> DRIVE_ENABLE)
        else $error("valid enable sequence did not enable drive");

    enoff_alarm_a: assert property (
        cmd_enable && !st_r.req_hi |=> st_r.alm_enoff && !DRIVE_ENABLE)
        else $error("enable while off did not raise alarm");

    alarm_hold_a: assert property (
        st_r.alm_enoff && !cmd_clear |=> st_r.alm_enoff)
        else $error("enabled-while-off alarm lost without clear");

    status_bit_a: assert property (
        status_read_s |=> PRDATA[`STS_TORQUE_OFF_BIT] == $past(st_r.req_hi) && PREADY)
        else $error("status bit does not show request level");

    undef_err_a: assert property (
        st_r.und_hi && ms_tick && st_r.und_ms == 32'(`UNDEF_LIMIT_MS) |=> st_r.err_undef)
        else $error("undefined band error not set");

    lamp_a: assert property (
        SAFETY_STATE_LAMP |-> $past(st_r.req_hi) && $past(st_r.boot_hi) && !$past(st_r.flt_hi))
        else $error("lamp lit without voltage, start-up or with fault");

    fault_iso_a: assert property (
        st_r.alm_fault && st_r.req_hi |=> GATE_SUPPLY_EN)
        else $error("fault alarm interfered with gate supply");

    // ------------------------------------------------------------------------
    // pulse filtering, sequencing, alarm and bus checks
    // ------------------------------------------------------------------------

    // a filtered low that has not yet outlasted the test-pulse window
    sequence short_low_s;
        st_r.req_ok && !st_r.req_hi && st_r.low_cnt < 32'(LOW_QUAL_CYC - 1);
    endsequence

    // drive running and software not asking to stop it
    sequence drive_kept_s;
        DRIVE_ENABLE && !cmd_disable;
    endsequence

    // a test pulse must not cost the drive its enable
    pulse_drive_a: assert property (
        drive_kept_s ##0 short_low_s |=> DRIVE_ENABLE)
        else $error("short low pulse dropped the drive");

    // the drive never comes up on its own
    no_auto_start_a: assert property (
        !DRIVE_ENABLE && !cmd_enable |=> !DRIVE_ENABLE)
        else $error("drive enabled without a command");

    alarm_block_a: assert property (
        !DRIVE_ENABLE && alarms_pending |=> !DRIVE_ENABLE)
        else $error("drive enabled with alarms pending");

    // a fault in the same cycle as a clear keeps its alarm
    set_wins_a: assert property (
        st_r.flt_hi |=> st_r.alm_fault)
        else $error("fault alarm not raised or lost to a clear");

    undef_hold_a: assert property (
        st_r.err_undef && !cmd_clear |=> st_r.err_undef)
        else $error("undefined band error lost without clear");

    lamp_boot_a: assert property (
        !st_r.boot_hi |=> !SAFETY_STATE_LAMP)
        else $error("lamp lit before start-up completed");

    lamp_alarm_a: assert property (
        alarms_pending |=> !SAFETY_STATE_LAMP)
        else $error("lamp lit with an alarm pending");

    // once removed, nothing but a high request brings the supply back
    removal_hold_a: assert property (
        !st_r.req_ok && !st_r.req_hi |=> !GATE_SUPPLY_EN)
        else $error("gate supply restored while request low");

    // status and alarms are read back in the first access cycle only
    ready_once_a: assert property (
        setup_ph |=> PREADY ##1 !PREADY)
        else $error("bus answer not a single cycle after setup");

    err_ready_a: assert property (
        PSLVERR |-> PREADY)
        else $error("slave error shown outside the answer cycle");

endmodule : torque_off_monitor

`default_nettype wire

// ==== torque_off_ctrl_model.sv ====
/*
 * Model of the external safety controller that drives the request pin.
 * Assumes it shares the monitor's clock and is steered by the bench tasks.
 */
`timescale 1ns/10ps
`default_nettype none
module torque_off_ctrl_model #(
    parameter int PULSE_MAX = 10
) (
    input wire logic clk,
    output logic req_n
);
    initial req_n = 1'b1;
    // hold the request low to remove torque, high to release it
    task automatic set_off(input bit off);
        @(posedge clk);
        req_n <= ~off;
    endtask : set_off
    // self-test low pulse, clipped to the longest allowed width
    task automatic test_pulse(input int n);
        int w;
        w = (n > PULSE_MAX) ? PULSE_MAX : n;
        @(posedge clk);
        req_n <= 1'b0;
        repeat (w) @(posedge clk);
        req_n <= 1'b1;
    endtask : test_pulse
endmodule : torque_off_ctrl_model
`default_nettype wire

// ==== tb_safe_torque_off_monitor.sv ====
/*
 * Self-checking bench of the torque-off monitor, APB reads checked from a queue.
 * Assumes the monitor's register header and a short qualify window.
 */
`timescale 1ns/10ps
`default_nettype none
`include "torque_off_regs.svh"
module tb_safe_torque_off_monitor;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
    localparam logic [31:0] S24 = 32'h0100_0000;
    localparam logic [31:0] E14 = 32'h0000_4000;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic und = 1'b0;
    logic flt = 1'b0;
    logic boot = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic req_n, gate, drv, lamp, pready, pslverr;
    logic [31:0] prdata;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    exp_t expq[$];

    always #4 clk = ~clk;

    torque_off_ctrl_model u_torque_off_ctrl_model (.clk(clk), .req_n(req_n));
    torque_off_monitor #(.LOW_QUAL_CYC(20), .MS_CYC(4)) u_torque_off_monitor (
        .CLK(clk), .SYS_RST(sys_rst), .TORQUE_OFF_REQUEST_N(req_n),
        .UNDEFINED_BAND(und), .CIRCUIT_FAULT(flt), .STARTUP_DONE(boot),
        .GATE_SUPPLY_EN(gate), .DRIVE_ENABLE(drv), .SAFETY_STATE_LAMP(lamp),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

    // ------------------------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------------------------
    task automatic cmp_word(input exp_t x, input logic [31:0] d, input logic e);
        cmp_count++;
        if (((d & x.m) !== (x.d & x.m)) || (e !== x.e))
        begin
            miscompares++;
            $display("BAD %0t apb data %h err %b, want %h", $time, d, e, x.d);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic got, input logic want);
        cmp_count++;
        if (got !== want)
        begin
            miscompares++;
            $display("BAD %0t pin level %b, want %b", $time, got, want);
        end
    endtask : cmp_bit
    // one full transfer; the expected answer is queued first
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] ed, input logic [31:0] em, input logic ee);
        exp_t x;
        x = '{ed, em, ee};
        expq.push_back(x);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] em);
        apb(1'b0, a, 32'h0000_0000, ed, em, 1'b0);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0000_0000, 32'h0000_0000, 1'b0);
    endtask : wr
    task automatic wait_gate(input logic v, input int n);
        for (int i = 0; i < n && gate !== v; i++) @(posedge clk);
        cmp_bit(gate, v);
    endtask : wait_gate
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    // takes the oldest note whenever the slave answers
    always @(posedge clk)
    begin
        cycles++;
        if (psel && penable && pready === 1'b1 && expq.size() > 0)
            cmp_word(expq.pop_front(), prdata, pslverr);
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(12916));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge clk);
        cmp_bit(lamp, 1'b0);
        rd(`OFS_INPUT_STATUS, S24, S24);
        rd(`OFS_DRIVE_STATE, 32'h0000_0002, 32'h0000_0003);
        rd(`OFS_CONTROL, 32'h0000_0000, ALL);
        apb(1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, ALL, 1'b1);
        wr(`OFS_CONTROL, 32'h0000_0001);
        rd(`OFS_DRIVE_STATE, 32'h0000_0003, 32'h0000_0003);
        boot <= 1'b1;
        repeat (8) @(posedge clk);
        cmp_bit(lamp, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            u_torque_off_ctrl_model.test_pulse(1 + $urandom % 10);
            repeat (30) @(posedge clk);
            rd(`OFS_DRIVE_STATE, 32'h0000_0003, 32'h0000_0003);
        end
        flt <= 1'b1;
        repeat (8) @(posedge clk);
        cmp_bit(lamp, 1'b0);
        rd(`OFS_ERROR, 32'h0000_0002, 32'h0000_0002);
        rd(`OFS_DRIVE_STATE, 32'h0000_0003, 32'h0000_0003);
        flt <= 1'b0;
        repeat (8) @(posedge clk);
        wr(`OFS_CONTROL, 32'h0000_0004);
        rd(`OFS_ERROR, 32'h0000_0000, 32'h0000_4003);
        u_torque_off_ctrl_model.set_off(1'b1);
        wait_gate(1'b0, 30);
        cmp_bit(drv, 1'b0);
        cmp_bit(lamp, 1'b0);
        rd(`OFS_INPUT_STATUS, 32'h0000_0000, S24);
        wr(`OFS_CONTROL, ALL);
        rd(`OFS_ERROR, 32'h0000_0001, 32'h0000_0001);
        rd(`OFS_DRIVE_STATE, 32'h0000_0000, 32'h0000_0003);
        u_torque_off_ctrl_model.set_off(1'b0);
        wait_gate(1'b1, 10);
        rd(`OFS_ERROR, 32'h0000_0001, 32'h0000_0001);
        rd(`OFS_DRIVE_STATE, 32'h0000_0002, 32'h0000_0003);
        wr(`OFS_CONTROL, 32'h0000_0001);
        rd(`OFS_DRIVE_STATE, 32'h0000_0002, 32'h0000_0003);
        wr(`OFS_CONTROL, 32'h0000_0004);
        rd(`OFS_ERROR, 32'h0000_0000, 32'h0000_4003);
        wr(`OFS_CONTROL, 32'h0000_0001);
        rd(`OFS_DRIVE_STATE, 32'h0000_0003, 32'h0000_0003);
        wr(`OFS_CONTROL, 32'h0000_0002);
        rd(`OFS_DRIVE_STATE, 32'h0000_0002, 32'h0000_0003);
        und <= 1'b1;
        repeat (1900) @(posedge clk);
        rd(`OFS_ERROR, 32'h0000_0000, E14);
        repeat (200) @(posedge clk);
        rd(`OFS_ERROR, E14, E14);
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule : tb_safe_torque_off_monitor
`default_nettype wire
